// file: cdid_decoder.sv
// module: instruction decoder of a character display controller
`timescale 1ns/10ps
// Summary of operation
// (R1) code 00000001 blanks display ram and zeroes address counter, within 6.2ms
// (R2) return home zeroes address counter and display shift, keeps display ram
// (R3) host keeps data bit 0 low when issuing return home
// (R4) entry mode sets move direction and display shift for data accesses
// (R5) display control stores enable, cursor and blink from bits 2..0
// (R6) shift with low bits 00 moves cursor or shifts display, ram untouched
// (R7) shift with low bits 11 sets graphic mode bit 3, power bit 2
// (R8) function set stores width, lines, font and two-bit font table
// (R9) set pattern address loads six bits and selects pattern ram
// (R10) bit 7 set loads seven-bit display address and selects display ram
// (R11) status read returns busy on bit 7 and address counter below
// (R12) data write stores byte into most recently addressed ram
// (R13) data read returns byte at current address of selected ram
// (R14) address counter steps by one after each data access, visible after busy
// (R15) busy reads 1 while an operation runs, 0 when ready
// (R16) entry shift bit 0 means no display shift on data accesses
// (R17) right/left bit 1 moves right, 0 moves left
// (R18) the highest set bit of an instruction byte selects the command
module cdid_decoder (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    // host access strobe (one pulse per bus cycle, from pin logic)
    input  wire logic       access_strobe,
    input  wire logic       register_select,
    input  wire logic       read_not_write,
    input  wire logic [7:0] data_in,
    // read data back to host
    output logic [7:0]      data_out,
    output logic            data_out_valid,
    // status and configuration
    output logic            busy_flag,
    output logic [6:0]      address_counter,
    output logic            pattern_ram_sel,
    output logic [6:0]      display_shift,
    output logic            entry_increment,
    output logic            entry_shift,
    output logic            display_enable,
    output logic            cursor_visible,
    output logic            cursor_blink,
    output logic            graphic_mode,
    output logic            internal_power,
    output logic            bus_width_select,
    output logic            two_lines,
    output logic            font_select,
    output logic            font_table_hi,
    output logic            font_table_lo
);
    import cdid_pkg::*;

    logic [SYNC_STAGES-1:0] strobe_sync_reg;
    logic                   strobe_seen_reg;
    logic [7:0]             disp_mem [DISP_DEPTH];
    logic [7:0]             pat_mem  [PAT_DEPTH];
    cdid_state_type         state_reg;
    logic [BUSY_W-1:0]      busy_cnt_reg;
    logic [6:0]             clear_idx_reg;
    logic [6:0]             ac_reg;
    logic [6:0]             ac_next;
    logic [6:0]             shift_reg;
    logic                   ac_step_pend_reg;
    cdid_cmd_type           cmd;
    logic                   strobe_pulse;
    logic                   instr_write;
    logic                   data_write;
    logic                   data_read;
    logic                   status_read;

    // highest set bit wins; lower bits are operands
    function automatic cdid_cmd_type decode_cmd(input logic [7:0] d);
        if (d[7])      decode_cmd = CDID_CMD_DISPADDR;
        else if (d[6]) decode_cmd = CDID_CMD_PATADDR;
        else if (d[5]) decode_cmd = CDID_CMD_FUNC;
        else if (d[4]) decode_cmd = CDID_CMD_SHIFT;
        else if (d[3]) decode_cmd = CDID_CMD_DISPCTL;
        else if (d[2]) decode_cmd = CDID_CMD_ENTRY;
        else if (d[1]) decode_cmd = CDID_CMD_HOME;
        else if (d[0]) decode_cmd = CDID_CMD_CLEAR;
        else           decode_cmd = CDID_CMD_NONE;
    endfunction

    // strobe crosses from the pin side; count a rising edge once stages 2 and 3 agree
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            strobe_sync_reg <= '0;
            strobe_seen_reg <= 1'b0;
        end else begin
            strobe_sync_reg <= {strobe_sync_reg[SYNC_STAGES-2:0], access_strobe};
            if (strobe_sync_reg[2] == strobe_sync_reg[1]) begin
                strobe_seen_reg <= strobe_sync_reg[2];
            end
        end
    end

    assign strobe_pulse = (strobe_sync_reg[2] == strobe_sync_reg[1]) &&
                          strobe_sync_reg[2] && !strobe_seen_reg;
    // while busy only the status read is honoured
    assign status_read = strobe_pulse && !register_select && read_not_write;
    assign instr_write = strobe_pulse && !register_select && !read_not_write &&
                         (state_reg == CDID_ST_IDLE);
    assign data_write  = strobe_pulse && register_select && !read_not_write &&
                         (state_reg == CDID_ST_IDLE);
    assign data_read   = strobe_pulse && register_select && read_not_write &&
                         (state_reg == CDID_ST_IDLE);
    assign cmd = decode_cmd(data_in); // R18

    // step direction from entry mode
    always_comb begin
        ac_next = entry_increment ? ac_reg + 7'h01 : ac_reg - 7'h01; // R14
        if (pattern_ram_sel) begin
            ac_next[6] = 1'b0;
        end
    end

    // busy sequencing
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_reg     <= CDID_ST_IDLE;
            busy_cnt_reg  <= '0;
            clear_idx_reg <= '0;
        end else begin
            case (state_reg)
                CDID_ST_IDLE: begin
                    if (instr_write && cmd == CDID_CMD_CLEAR) begin
                        state_reg     <= CDID_ST_CLEAR; // R1
                        clear_idx_reg <= '0;
                    end else if (instr_write || data_write || data_read) begin
                        state_reg    <= CDID_ST_WAIT;
                        busy_cnt_reg <= BUSY_W'(SHORT_CYCLES - 1);
                    end
                end
                CDID_ST_CLEAR: begin
                    clear_idx_reg <= clear_idx_reg + 7'h01;
                    if (clear_idx_reg == 7'h7F) begin
                        state_reg    <= CDID_ST_WAIT;
                        busy_cnt_reg <= BUSY_W'(CLEAR_CYCLES - DISP_DEPTH - 1); // R1
                    end
                end
                CDID_ST_WAIT: begin
                    if (busy_cnt_reg == '0) begin
                        state_reg <= CDID_ST_IDLE;
                    end else begin
                        busy_cnt_reg <= busy_cnt_reg - 1'b1;
                    end
                end
                default: state_reg <= CDID_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            busy_flag <= 1'b0;
        end else begin
            busy_flag <= (state_reg != CDID_ST_WAIT || busy_cnt_reg != '0) &&
                         (state_reg != CDID_ST_IDLE ||
                          instr_write || data_write || data_read); // R15
        end
    end

    // address counter and ram select
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ac_reg           <= HOME_ADDR;
            pattern_ram_sel  <= 1'b0;
            ac_step_pend_reg <= 1'b0;
        end else begin
            if (instr_write && (cmd == CDID_CMD_CLEAR || cmd == CDID_CMD_HOME)) begin
                ac_reg          <= HOME_ADDR; // R1 R2
                pattern_ram_sel <= 1'b0;
            end else if (instr_write && cmd == CDID_CMD_PATADDR) begin
                ac_reg          <= {1'b0, data_in[5:0]}; // R9
                pattern_ram_sel <= 1'b1;
            end else if (instr_write && cmd == CDID_CMD_DISPADDR) begin
                ac_reg          <= data_in[6:0]; // R10
                pattern_ram_sel <= 1'b0;
            end else if (instr_write && cmd == CDID_CMD_SHIFT && data_in[1:0] == 2'b00 &&
                         !data_in[3]) begin
                ac_reg <= data_in[2] ? ac_reg + 7'h01 : ac_reg - 7'h01; // R6 R17
                // pattern ram has six address bits; a move must not leave it
                if (pattern_ram_sel) begin
                    ac_reg[6] <= 1'b0; // R9
                end
            end
            // new address appears as busy drops
            if (data_write || data_read) begin
                ac_step_pend_reg <= 1'b1;
            end else if (ac_step_pend_reg && state_reg == CDID_ST_WAIT &&
                         busy_cnt_reg == '0) begin
                ac_step_pend_reg <= 1'b0;
                ac_reg           <= ac_next; // R14
            end
        end
    end

    // display shift offset
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            shift_reg <= SHIFT_RESET;
        end else if (instr_write && (cmd == CDID_CMD_CLEAR || cmd == CDID_CMD_HOME)) begin
            shift_reg <= SHIFT_RESET; // R2
        end else if (instr_write && cmd == CDID_CMD_SHIFT && data_in[1:0] == 2'b00 &&
                     data_in[3]) begin
            shift_reg <= data_in[2] ? shift_reg + 7'h01 : shift_reg - 7'h01; // R6 R17
        end else if ((data_write || data_read) && entry_shift) begin
            // shift runs against cursor direction; shift bit 0 leaves it alone
            shift_reg <= entry_increment ? shift_reg - 7'h01 : shift_reg + 7'h01; // R4 R16
        end
    end

    // configuration latches
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            {entry_increment, entry_shift} <= {ENTRY_INC_RESET, ENTRY_SHIFT_RESET};
            {display_enable, cursor_visible, cursor_blink} <= DISP_CTRL_RESET;
            {graphic_mode, internal_power} <= {GRAPHIC_RESET, POWER_RESET};
            {bus_width_select, two_lines, font_select, font_table_hi, font_table_lo}
                <= FUNC_RESET;
        end else if (instr_write) begin
            case (cmd)
                CDID_CMD_ENTRY:   {entry_increment, entry_shift} <= data_in[1:0]; // R4
                CDID_CMD_DISPCTL: {display_enable, cursor_visible, cursor_blink}
                                      <= data_in[2:0]; // R5
                CDID_CMD_SHIFT: begin
                    if (data_in[1:0] == 2'b11) begin
                        {graphic_mode, internal_power} <= data_in[3:2]; // R7
                    end
                end
                CDID_CMD_FUNC: {bus_width_select, two_lines, font_select,
                                font_table_hi, font_table_lo} <= data_in[4:0]; // R8
                default: ;
            endcase
        end
    end

    // ram writes; no reset on the arrays
    always_ff @(posedge clk_sys) begin
        if (state_reg == CDID_ST_CLEAR) begin
            disp_mem[clear_idx_reg] <= BLANK_CHAR; // R1
        end else if (data_write && !pattern_ram_sel) begin
            disp_mem[ac_reg] <= data_in; // R12
        end
        if (data_write && pattern_ram_sel) begin
            pat_mem[ac_reg[5:0]] <= data_in; // R12
        end
    end

    // read answers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            data_out       <= 8'h00;
            data_out_valid <= 1'b0;
        end else begin
            data_out_valid <= status_read || data_read;
            if (status_read) begin
                data_out <= {busy_flag, ac_reg}; // R11
            end else if (data_read) begin
                data_out <= pattern_ram_sel ? pat_mem[ac_reg[5:0]] : disp_mem[ac_reg]; // R13
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            address_counter <= HOME_ADDR;
            display_shift   <= SHIFT_RESET;
        end else begin
            address_counter <= ac_reg;
            display_shift   <= shift_reg;
        end
    end
endmodule // cdid_decoder

// file: cdid_pkg.sv
// package: constants and types for the character display instruction decoder
package cdid_pkg;
    localparam int unsigned CLK_HZ           = 10_000_000;
    localparam int unsigned CLEAR_TIME_US    = 6200;
    localparam int unsigned CLEAR_CYCLES     = (CLEAR_TIME_US * (CLK_HZ / 1_000_000));
    localparam int unsigned SHORT_TIME_US    = 40;
    localparam int unsigned SHORT_CYCLES     = (SHORT_TIME_US * (CLK_HZ / 1_000_000));
    localparam int unsigned BUSY_W           = 16;
    localparam int unsigned DISP_DEPTH       = 128;
    localparam int unsigned PAT_DEPTH        = 64;
    localparam logic [7:0]  BLANK_CHAR       = 8'h20;
    localparam logic [6:0]  HOME_ADDR        = 7'h00;
    localparam logic [6:0]  SHIFT_RESET      = 7'h00;
    localparam logic        ENTRY_INC_RESET  = 1'b1;
    localparam logic        ENTRY_SHIFT_RESET = 1'b0;
    localparam logic [2:0]  DISP_CTRL_RESET  = 3'h0;
    localparam logic [4:0]  FUNC_RESET       = 5'h18;
    localparam logic        GRAPHIC_RESET    = 1'b0;
    localparam logic        POWER_RESET      = 1'b0;
    localparam int unsigned SYNC_STAGES      = 3;

    typedef enum logic [3:0] {
        CDID_CMD_NONE, CDID_CMD_CLEAR, CDID_CMD_HOME, CDID_CMD_ENTRY, CDID_CMD_DISPCTL,
        CDID_CMD_SHIFT, CDID_CMD_FUNC, CDID_CMD_PATADDR, CDID_CMD_DISPADDR
    } cdid_cmd_type;

    typedef enum logic [1:0] {
        CDID_ST_IDLE, CDID_ST_CLEAR, CDID_ST_WAIT
    } cdid_state_type;
endpackage : cdid_pkg

// file: cdid_checker.sv
// port-level assertions for the instruction decoder
`timescale 1ns/10ps
module cdid_checker
    import cdid_pkg::*;
(
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       arst_n,
    // host side
    input wire logic       access_strobe,
    input wire logic       register_select,
    input wire logic       read_not_write,
    // answers and state
    input wire logic [7:0] data_out,
    input wire logic       data_out_valid,
    input wire logic       busy_flag,
    input wire logic [6:0] address_counter,
    input wire logic       pattern_ram_sel,
    input wire logic [6:0] display_shift,
    input wire logic       display_enable,
    input wire logic       graphic_mode,
    input wire logic       internal_power,
    input wire logic       bus_width_select,
    input wire logic       font_table_lo
);
    logic [16:0] bcnt_reg;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // length of the running busy period, judged when it ends
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) bcnt_reg <= 17'h00000;
        else bcnt_reg <= busy_flag ? bcnt_reg + 17'h00001 : 17'h00000;
    end
    valid_pulse_a: assert property (data_out_valid |=> !data_out_valid)
        else $error("read pulse longer than one cycle");
    valid_cause_a: assert property (data_out_valid |->
        $past(access_strobe, 3) && $past(read_not_write, 3))
        else $error("read answer without a read cycle");
    busy_cause_a: assert property ($rose(busy_flag) |-> $past(access_strobe, 2))
        else $error("busy rose without a bus cycle");
    busy_hold_a: assert property ($rose(busy_flag) |=> busy_flag [*8])
        else $error("busy dropped too early");
    busy_len_a: assert property ($fell(busy_flag) |->
        bcnt_reg >= 17'h00186 && bcnt_reg <= CLEAR_CYCLES + 4)
        else $error("busy period out of range");
    status_ac_a: assert property (data_out_valid && !register_select |->
        data_out[6:0] == address_counter)
        else $error("status read address mismatch");
    pat_bit_a: assert property (pattern_ram_sel [*3] |-> !address_counter[6])
        else $error("pattern address above six bits");
    cfg_busy_a: assert property ($changed({display_enable, graphic_mode, internal_power}) |->
        ##[0:2] busy_flag)
        else $error("display setting changed without an instruction");
    func_busy_a: assert property ($changed({bus_width_select, font_table_lo}) |->
        ##[0:2] busy_flag)
        else $error("function setting changed without an instruction");
    shift_busy_a: assert property ($changed(display_shift) |-> ##[0:2] busy_flag)
        else $error("display shift changed without an operation");
    status_c: cover property (data_out_valid && !register_select && data_out[7]);
    long_c: cover property ($fell(busy_flag) && bcnt_reg > 17'h003E8);
    pat_c: cover property (data_out_valid && pattern_ram_sel);
endmodule // cdid_checker

// file: cdid_host.sv
// host processor model driving the decoder bus strobe
`timescale 1ns/10ps
module cdid_host (
    // clock and status
    input  wire logic       clk_sys,
    input  wire logic       busy_flag,
    // bus cycle
    output logic            access_strobe,
    output logic            register_select,
    output logic            read_not_write,
    output logic [7:0]      data_in
);
    initial begin
        access_strobe = 1'b0;
        register_select = 1'b0;
        read_not_write = 1'b1;
        data_in = 8'h00;
    end
    // one bus cycle; without poll it may land while busy
    task automatic op(input logic rs, input logic rnw, input logic [7:0] d, input logic poll);
        if (poll) begin
            @(negedge clk_sys);
            while (busy_flag !== 1'b0) @(negedge clk_sys);
        end
        if (!rs && !rnw && d[7:1] == 7'h01) d[0] = 1'b0;
        @(negedge clk_sys);
        register_select = rs;
        read_not_write = rnw;
        data_in = d;
        access_strobe = 1'b1;
        // held well past the synchroniser depth
        repeat (6) @(negedge clk_sys);
        access_strobe = 1'b0;
        // released bus must not look like the last byte
        data_in = ~d;
        repeat (3) @(negedge clk_sys);
    endtask
endmodule // cdid_host

// file: tb.sv
// self-checking bench for the instruction decoder
`timescale 1ns/10ps
module tb;
    import cdid_pkg::*;
    logic       clk_sys = 1'b0;
    logic       arst_n = 1'b0;
    logic       access_strobe, register_select, read_not_write, data_out_valid, busy_flag;
    logic       pattern_ram_sel, entry_increment, entry_shift, display_enable, cursor_visible;
    logic       cursor_blink, graphic_mode, internal_power, bus_width_select, two_lines;
    logic       font_select, font_table_hi, font_table_lo;
    logic [7:0] data_in, data_out, r, b;
    logic [6:0] address_counter, display_shift, a;
    logic [7:0] exp_q[$];
    int         failures = 0;
    int         comparisons = 0;
    int         cycles = 0;
    int         seed = 32'hd74e8c7c;
    always #50 clk_sys = ~clk_sys;
    cdid_decoder dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .access_strobe(access_strobe),
        .register_select(register_select), .read_not_write(read_not_write), .data_in(data_in),
        .data_out(data_out), .data_out_valid(data_out_valid), .busy_flag(busy_flag),
        .address_counter(address_counter), .pattern_ram_sel(pattern_ram_sel),
        .display_shift(display_shift), .entry_increment(entry_increment),
        .entry_shift(entry_shift), .display_enable(display_enable), .cursor_visible(cursor_visible),
        .cursor_blink(cursor_blink), .graphic_mode(graphic_mode), .internal_power(internal_power),
        .bus_width_select(bus_width_select), .two_lines(two_lines), .font_select(font_select),
        .font_table_hi(font_table_hi), .font_table_lo(font_table_lo));
    cdid_host host_u (.clk_sys(clk_sys), .busy_flag(busy_flag), .access_strobe(access_strobe),
        .register_select(register_select), .read_not_write(read_not_write), .data_in(data_in));
    task automatic test_done;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    // read results; an answer with no note is a mismatch
    task automatic chk_read(input logic [7:0] s);
        if (exp_q.size() > 0) begin
            chk("read data", exp_q.pop_front(), s);
        end else begin
            comparisons++;
            failures++;
            $display("wrong value read data expected none seen %h", s);
        end
    endtask
    task automatic cmd(input logic [7:0] d);
        host_u.op(1'b0, 1'b0, d, 1'b1);
    endtask
    task automatic wr(input logic [7:0] d);
        host_u.op(1'b1, 1'b0, d, 1'b1);
    endtask
    task automatic rd(input logic rs, input logic [7:0] e, input logic poll);
        exp_q.push_back(e);
        host_u.op(rs, 1'b1, 8'h00, poll);
    endtask
    // read answers are matched in order against the notes
    // sampled mid-cycle, where the one-cycle pulse has settled
    always @(negedge clk_sys) begin
        if (data_out_valid === 1'b1) chk_read(data_out);
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 95000) begin
            failures++;
            test_done();
        end
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys) arst_n = 1'b1;
        chk("entry", 8'h02, {6'h0, entry_increment, entry_shift});
        r = 8'($random(seed));
        b = 8'($random(seed));
        a = r[6:0] & 7'h3F;
        cmd({3'h1, r[4:0]});
        chk("func", {3'h0, r[4:0]}, {3'h0, bus_width_select, two_lines, font_select,
            font_table_hi, font_table_lo});
        cmd({5'h01, r[7:5]});
        chk("disp", {5'h0, r[7:5]}, {5'h0, display_enable, cursor_visible, cursor_blink});
        for (int i = 0; i < 4; i++) begin
            cmd({4'h1, i[1:0], 2'h3});
            chk("mode", {6'h0, i[1:0]}, {6'h0, graphic_mode, internal_power});
        end
        cmd({1'b1, a});
        rd(1'b0, {1'b0, a}, 1'b1);
        chk("ac", {1'b0, a}, {1'b0, address_counter});
        wr(b);
        rd(1'b0, {1'b1, a}, 1'b0);
        host_u.op(1'b0, 1'b0, 8'h0F, 1'b0);
        rd(1'b0, {1'b0, a + 7'h01}, 1'b1);
        chk("disp", {5'h0, r[7:5]}, {5'h0, display_enable, cursor_visible, cursor_blink});
        chk("shift", 8'h00, {1'b0, display_shift});
        cmd({1'b1, a});
        rd(1'b1, b, 1'b1);
        rd(1'b0, {1'b0, a + 7'h01}, 1'b1);
        cmd(8'h04);
        chk("entry", 8'h00, {6'h0, entry_increment, entry_shift});
        wr(b);
        rd(1'b0, {1'b0, a}, 1'b1);
        cmd(8'h14);
        rd(1'b0, {1'b0, a + 7'h01}, 1'b1);
        cmd(8'h10);
        cmd(8'h00);
        rd(1'b0, {1'b0, a}, 1'b1);
        cmd(8'h1C);
        chk("shift", 8'h01, {1'b0, display_shift});
        cmd(8'h18);
        cmd(8'h18);
        chk("shift", 8'h7F, {1'b0, display_shift});
        cmd(8'h07);
        chk("entry", 8'h03, {6'h0, entry_increment, entry_shift});
        wr(b);
        chk("shift", 8'h7E, {1'b0, display_shift});
        cmd(8'h03);
        chk("shift", 8'h00, {1'b0, display_shift});
        rd(1'b0, 8'h00, 1'b1);
        cmd({1'b1, a});
        rd(1'b1, b, 1'b1);
        cmd({2'h1, a[5:0]});
        wr(r);
        cmd({2'h1, a[5:0]});
        rd(1'b1, r, 1'b1);
        chk("sel", 8'h01, {7'h0, pattern_ram_sel});
        // cursor move past the top pattern address wraps within six bits
        cmd(8'h7F);
        cmd(8'h14);
        rd(1'b0, 8'h00, 1'b1);
        cmd(8'h01);
        rd(1'b0, 8'h00, 1'b1);
        rd(1'b1, BLANK_CHAR, 1'b1);
        chk("sel", 8'h00, {7'h0, pattern_ram_sel});
        repeat (4) @(negedge clk_sys);
        test_done();
    end
endmodule // tb
bind cdid_decoder cdid_checker chk_u (.clk_sys(clk_sys), .arst_n(arst_n),
    .access_strobe(access_strobe), .register_select(register_select),
    .read_not_write(read_not_write), .data_out(data_out), .data_out_valid(data_out_valid),
    .busy_flag(busy_flag), .address_counter(address_counter), .pattern_ram_sel(pattern_ram_sel),
    .display_shift(display_shift), .display_enable(display_enable), .graphic_mode(graphic_mode),
    .internal_power(internal_power), .bus_width_select(bus_width_select),
    .font_table_lo(font_table_lo));
